// ---- shared/isr_pkg.sv ----
// Constants and carrier types for the service request and remote/local block.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
package isr_pkg;

    // ----------------------------------------------------------------
    // Interface sizes
    // ----------------------------------------------------------------
    localparam int NUM_OUTPUTS = 4;
    localparam int ADDR_W = 5;
    localparam int SPOLL_W = 8;

    // ----------------------------------------------------------------
    // Status byte layout and address limits
    // ----------------------------------------------------------------
    localparam int RQS_BIT = 6;
    localparam int PROG_ERR_BIT = 5;
    localparam int PON_BIT = 4;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 5'h1E;
    localparam logic [ADDR_W-1:0] PPOLL_ADDR_MAX = 5'h07;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h05;

    // ----------------------------------------------------------------
    // Interrupt status/mask bit positions
    // ----------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_SRQ = 0;
    localparam int IRQ_ADDR_ERR = 1;
    localparam int IRQ_LOCAL_REFUSED = 2;
    localparam int IRQ_LOCKOUT = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] REG_ADDR = 4'h1;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h2;
    localparam logic [REG_AW-1:0] REG_IRQ_STAT = 4'h3;
    localparam logic [REG_AW-1:0] REG_IRQ_MASK = 4'h4;
    localparam logic [REG_AW-1:0] REG_PPOLL_CFG = 4'h5;
    localparam int CTRL_PON_EN = 0;
    localparam int CTRL_SEL_W = 3;
    localparam int PPCFG_SEL_LSB = 0;
    localparam int PPCFG_SENSE = 3;
    localparam int PPCFG_EN = 4;

    // Register port carrier
    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } isr_reg_req_type;

    // Bus-side events from the interface chips
    typedef struct packed {
        logic serial_poll;
        logic parallel_poll;
        logic clear_supply_command;
        logic go_remote;
        logic go_local;
        logic local_lockout;
        logic lockout_release;
        logic listen_addr;
        logic talk_addr;
    } isr_bus_ev_type;

    typedef enum logic [1:0] {
        RL_LOCAL,
        RL_REMOTE,
        RL_LOCKOUT
    } isr_rl_state_type;

endpackage : isr_pkg

// ---- hdl/isr_top.sv ----
// Service request, poll response and remote/local arbitration logic.
// Assumes bus handshake/address recognition is done by interface chips
// that deliver one-cycle event pulses synchronous to clk_sys_i.
//
// Chosen here: the strobed register port and the register addresses.
module isr_top #(
    parameter int NUM_OUTPUTS = isr_pkg::NUM_OUTPUTS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire isr_pkg::isr_reg_req_type reg_req_i,
    output logic [7:0] reg_rdata_o,
    // Instrument events
    input wire logic [NUM_OUTPUTS-1:0] output_fault_i,
    input wire logic prog_error_i,
    input wire logic power_on_i,
    input wire logic remote_cmd_busy_i,
    // Bus events
    input wire isr_pkg::isr_bus_ev_type bus_ev_i,
    // Front panel
    input wire logic front_panel_local_key_i,
    input wire logic panel_write_req_i,
    output logic panel_write_en_o,
    // Bus outputs
    output logic srq_o,
    output logic [7:0] poll_data_o,
    output logic [7:0] poll_data_oe_o,
    // Indicators and interrupt
    output logic srq_ind_o,
    output logic addr_ind_o,
    output logic remote_o,
    output logic addr_err_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic rqs_q;
    logic pon_en_q;
    logic [NUM_OUTPUTS-1:0] fault_prev_q;
    logic [NUM_OUTPUTS-1:0] fault_rise;
    logic prog_err_flag_q;
    logic pon_flag_q;
    logic [isr_pkg::ADDR_W-1:0] addr_q;
    logic addr_err_q;
    logic listen_q;
    logic talk_q;
    logic [4:0] ppcfg_q;
    logic [isr_pkg::IRQ_W-1:0] irq_stat_q;
    logic [isr_pkg::IRQ_W-1:0] irq_mask_q;
    isr_pkg::isr_rl_state_type rl_q;
    logic [7:0] status_byte;
    logic raise;
    logic rqs_clr;
    logic local_refused;
    logic addr_wr;
    logic addr_bad;

    function automatic logic [7:0] sel_line(input logic [2:0] sel);
        sel_line = 8'h01 << sel;
    endfunction : sel_line

    // ----------------------------------------------------------------
    // Service request generation
    // ----------------------------------------------------------------
    // Fault edge detection, one lane per output
    for (genvar gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_fault_rise
        assign fault_rise[gi] = output_fault_i[gi] & ~fault_prev_q[gi];
    end

    // A new cause outranks a poll in the same cycle so no event is lost
    assign raise = (|fault_rise) | prog_error_i
        | (power_on_i & pon_en_q);
    assign rqs_clr = bus_ev_i.serial_poll | bus_ev_i.clear_supply_command;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fault_prev_q <= '0;
        end else begin
            fault_prev_q <= output_fault_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rqs_q <= 1'b0;
        end else if (raise) begin
            rqs_q <= 1'b1;
        end else if (rqs_clr) begin
            rqs_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prog_err_flag_q <= 1'b0;
            pon_flag_q <= 1'b0;
        end else begin
            if (prog_error_i) begin
                prog_err_flag_q <= 1'b1;
            end else if (rqs_clr) begin
                prog_err_flag_q <= 1'b0;
            end
            if (power_on_i & pon_en_q) begin
                pon_flag_q <= 1'b1;
            end else if (rqs_clr) begin
                pon_flag_q <= 1'b0;
            end
        end
    end

    // Request line, indicator and status bit share the same flip-flop
    assign srq_o = rqs_q;
    assign srq_ind_o = rqs_q;

    always_comb begin
        status_byte = 8'h00;
        status_byte[isr_pkg::RQS_BIT] = rqs_q;
        status_byte[isr_pkg::PROG_ERR_BIT] = prog_err_flag_q;
        status_byte[isr_pkg::PON_BIT] = pon_flag_q;
        // Live fault levels fill the low bits
        status_byte[NUM_OUTPUTS-1:0] = output_fault_i;
    end

    // ----------------------------------------------------------------
    // Poll response
    // ----------------------------------------------------------------
    // Serial poll answer wins over a parallel poll in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            poll_data_o <= 8'h00;
            poll_data_oe_o <= 8'h00;
        end else if (bus_ev_i.serial_poll) begin
            poll_data_o <= status_byte;
            poll_data_oe_o <= 8'hFF;
        end else if (bus_ev_i.parallel_poll) begin
            if (ppcfg_q[isr_pkg::PPCFG_EN]) begin
                poll_data_o <= (rqs_q == ppcfg_q[isr_pkg::PPCFG_SENSE])
                    ? sel_line(ppcfg_q[2:0]) : 8'h00;
                poll_data_oe_o <= sel_line(ppcfg_q[2:0]);
            end else if (addr_q <= isr_pkg::PPOLL_ADDR_MAX) begin
                // Default answer drives the line only while requesting
                poll_data_o <= rqs_q ? sel_line(addr_q[2:0]) : 8'h00;
                poll_data_oe_o <= rqs_q ? sel_line(addr_q[2:0]) : 8'h00;
            end else begin
                poll_data_o <= 8'h00;
                poll_data_oe_o <= 8'h00;
            end
        end else begin
            poll_data_o <= 8'h00;
            poll_data_oe_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    assign addr_wr = reg_req_i.wr && (reg_req_i.addr == isr_pkg::REG_ADDR);
    assign addr_bad = reg_req_i.wdata > {3'h0, isr_pkg::ADDR_MAX};

    // Out-of-range writes keep the old address and only flag the error
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_q <= isr_pkg::ADDR_RESET;
            addr_err_q <= 1'b0;
        end else if (addr_wr) begin
            addr_err_q <= addr_bad;
            if (!addr_bad) begin
                addr_q <= reg_req_i.wdata[isr_pkg::ADDR_W-1:0];
            end
        end
    end

    // Device clear leaves addressing alone; the interface chips own it
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
        end else begin
            listen_q <= bus_ev_i.listen_addr;
            talk_q <= bus_ev_i.talk_addr;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_ind_o <= 1'b0;
            addr_err_o <= 1'b0;
        end else begin
            addr_ind_o <= listen_q | talk_q;
            addr_err_o <= addr_err_q;
        end
    end

    // ----------------------------------------------------------------
    // Remote/local arbitration
    // ----------------------------------------------------------------
    assign local_refused = front_panel_local_key_i
        && ((rl_q == isr_pkg::RL_LOCKOUT)
        || (rl_q == isr_pkg::RL_REMOTE && remote_cmd_busy_i));

    // Lockout is left only by the controller's release
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rl_q <= isr_pkg::RL_LOCAL;
        end else begin
            unique case (rl_q)
                isr_pkg::RL_LOCAL: begin
                    if (bus_ev_i.local_lockout) begin
                        rl_q <= isr_pkg::RL_LOCKOUT;
                    end else if (bus_ev_i.go_remote) begin
                        rl_q <= isr_pkg::RL_REMOTE;
                    end
                end
                isr_pkg::RL_REMOTE: begin
                    if (bus_ev_i.local_lockout) begin
                        rl_q <= isr_pkg::RL_LOCKOUT;
                    end else if (bus_ev_i.go_local) begin
                        rl_q <= isr_pkg::RL_LOCAL;
                    end else if (front_panel_local_key_i && !remote_cmd_busy_i) begin
                        rl_q <= isr_pkg::RL_LOCAL;
                    end
                end
                isr_pkg::RL_LOCKOUT: begin
                    if (bus_ev_i.lockout_release) begin
                        rl_q <= isr_pkg::RL_LOCAL;
                    end
                end
                default: begin
                    rl_q <= isr_pkg::RL_LOCAL;
                end
            endcase
        end
    end

    // Only the write gate and remote_o change with mode; settings live elsewhere
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            panel_write_en_o <= 1'b0;
            remote_o <= 1'b0;
        end else begin
            panel_write_en_o <= panel_write_req_i && (rl_q == isr_pkg::RL_LOCAL);
            remote_o <= rl_q != isr_pkg::RL_LOCAL;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pon_en_q <= 1'b0;
            ppcfg_q <= 5'h00;
            irq_mask_q <= '0;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == isr_pkg::REG_CTRL) begin
                pon_en_q <= reg_req_i.wdata[isr_pkg::CTRL_PON_EN];
            end
            if (reg_req_i.addr == isr_pkg::REG_PPOLL_CFG) begin
                ppcfg_q <= reg_req_i.wdata[4:0];
            end
            if (reg_req_i.addr == isr_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= reg_req_i.wdata[isr_pkg::IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: set wins over read-clear
    // ----------------------------------------------------------------
    logic [isr_pkg::IRQ_W-1:0] irq_set;
    logic irq_rd;

    always_comb begin
        irq_set = '0;
        irq_set[isr_pkg::IRQ_SRQ] = raise;
        irq_set[isr_pkg::IRQ_ADDR_ERR] = addr_wr && addr_bad;
        irq_set[isr_pkg::IRQ_LOCAL_REFUSED] = local_refused;
        irq_set[isr_pkg::IRQ_LOCKOUT] = bus_ev_i.local_lockout;
    end

    assign irq_rd = reg_req_i.rd && (reg_req_i.addr == isr_pkg::REG_IRQ_STAT);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else if (irq_rd) begin
            irq_stat_q <= irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Mask applies to the updated status so the output follows in one cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_rd ? '0 : irq_stat_q) | irq_set) & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                isr_pkg::REG_CTRL: reg_rdata_o <= {7'h00, pon_en_q};
                isr_pkg::REG_ADDR: reg_rdata_o <= {addr_err_q, 2'h0, addr_q};
                isr_pkg::REG_STATUS: reg_rdata_o <= status_byte;
                isr_pkg::REG_IRQ_STAT: reg_rdata_o <= {4'h0, irq_stat_q};
                isr_pkg::REG_IRQ_MASK: reg_rdata_o <= {4'h0, irq_mask_q};
                isr_pkg::REG_PPOLL_CFG: reg_rdata_o <= {3'h0, ppcfg_q};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule : isr_top

// ---- tb/isr_asserts.sv ----
// Port-level checker for isr_top.
// Assumes one clock and a synchronous active-high reset; bound below.
module isr_asserts #(
    parameter int NUM_OUTPUTS = isr_pkg::NUM_OUTPUTS
) (
    // Clock, reset and causes
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [NUM_OUTPUTS-1:0] output_fault_i,
    input wire logic prog_error_i,
    input wire logic power_on_i,
    input wire isr_pkg::isr_bus_ev_type bus_ev_i,
    // Observed outputs
    input wire logic panel_write_en_o,
    input wire logic srq_o,
    input wire logic [7:0] poll_data_o,
    input wire logic [7:0] poll_data_oe_o,
    input wire logic srq_ind_o,
    input wire logic addr_ind_o,
    input wire logic remote_o
);
    logic [NUM_OUTPUTS-1:0] fault_q;
    logic raise;
    always_ff @(posedge clk_sys_i) begin
        fault_q <= output_fault_i;
    end
    assign raise = prog_error_i | power_on_i | (|(output_fault_i & ~fault_q));
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_spoll; bus_ev_i.serial_poll && !raise; endsequence
    sequence s_clear; bus_ev_i.clear_supply_command && !raise; endsequence
    sequence s_ppoll;
        bus_ev_i.parallel_poll && !raise && !bus_ev_i.serial_poll
            && !bus_ev_i.clear_supply_command;
    endsequence
    sequence s_addr; (bus_ev_i.listen_addr || bus_ev_i.talk_addr) [*3]; endsequence
    sequence s_idle; (!bus_ev_i.listen_addr && !bus_ev_i.talk_addr) [*3]; endsequence
    sequence s_ind_lit;
        srq_ind_o && !bus_ev_i.serial_poll && !bus_ev_i.clear_supply_command;
    endsequence
    chk_error_raise: assert property (prog_error_i |=> srq_o)
        else $error("request not raised by error");
    chk_fault_raise: assert property (|(output_fault_i & ~fault_q) |=> srq_o && srq_ind_o)
        else $error("request not raised by fault");
    chk_spoll_clear: assert property (s_spoll |=> !srq_o && !srq_ind_o)
        else $error("serial poll left request");
    chk_clear_cmd: assert property (s_clear |=> !srq_o)
        else $error("clear left request");
    chk_spoll_byte: assert property (s_spoll |=> poll_data_oe_o == 8'hFF
        && poll_data_o[isr_pkg::RQS_BIT] == $past(srq_o))
        else $error("serial poll byte wrong");
    chk_ppoll_keep: assert property (s_ppoll |=> $stable(srq_o))
        else $error("parallel poll changed request");
    chk_ind_hold: assert property (s_ind_lit |=> srq_ind_o)
        else $error("indicator went out before poll");
    chk_panel_block: assert property (remote_o |-> !panel_write_en_o)
        else $error("panel write in remote");
    chk_addr_ind: assert property (s_addr |-> addr_ind_o)
        else $error("addressed indicator off");
    chk_addr_idle: assert property (s_idle |-> !addr_ind_o)
        else $error("addressed indicator on");
endmodule : isr_asserts

bind isr_top isr_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_chk (.clk_sys_i, .rst_i, .output_fault_i,
    .prog_error_i, .power_on_i, .bus_ev_i, .panel_write_en_o, .srq_o, .poll_data_o,
    .poll_data_oe_o, .srq_ind_o, .addr_ind_o, .remote_o);

// ---- tb/isr_ctrl_model.sv ----
// Bus controller model: passes bench commands on as bus events.
// Serial-polls on its own when its parallel poll finds a request.
module isr_ctrl_model (
    input wire logic clk_sys_i,
    input wire isr_pkg::isr_bus_ev_type cmd_i,
    input wire logic [7:0] pp_oe_i,
    input wire logic [7:0] pp_d_i,
    output isr_pkg::isr_bus_ev_type bus_ev_o
);
    logic pp_q;
    always_ff @(posedge clk_sys_i) begin
        pp_q <= cmd_i.parallel_poll;
    end
    always_comb begin
        bus_ev_o = cmd_i;
        if (pp_q && (|(pp_oe_i & pp_d_i))) bus_ev_o.serial_poll = 1'b1;
    end
endmodule : isr_ctrl_model

// ---- tb/ieee488_service_request_remote_tb_top.sv ----
// Self-checking bench for isr_top with a bus controller model.
// Assumes 25 MHz clock; bus event order 8 spoll 7 ppoll 6 clear 5 remote 4 local 3 lockout 2 release.
module ieee488_service_request_remote_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    isr_pkg::isr_reg_req_type req_q = '0;
    isr_pkg::isr_bus_ev_type cmd_q = '0;
    isr_pkg::isr_bus_ev_type bus_ev;
    logic [3:0] fault_q = '0;
    logic [3:0] misc_q = '0;
    logic busy_q = 1'b0;
    logic [7:0] rdata, poll_d, poll_oe, d;
    logic pw_en, srq, srq_ind, a_ind, remote, a_err, irq, x;
    logic [4:0] a;
    logic [2:0] ln;
    int bad_count = 0;
    int num_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    isr_top u_dut (.clk_sys_i, .rst_i, .reg_req_i(req_q), .reg_rdata_o(rdata),
        .output_fault_i(fault_q), .prog_error_i(misc_q[0]), .power_on_i(misc_q[1]),
        .remote_cmd_busy_i(busy_q), .bus_ev_i(bus_ev), .front_panel_local_key_i(misc_q[2]),
        .panel_write_req_i(misc_q[3]), .panel_write_en_o(pw_en), .srq_o(srq), .poll_data_o(poll_d),
        .poll_data_oe_o(poll_oe), .srq_ind_o(srq_ind), .addr_ind_o(a_ind), .remote_o(remote),
        .addr_err_o(a_err), .irq_o(irq));
    isr_ctrl_model u_ctrl (.clk_sys_i, .cmd_i(cmd_q), .pp_oe_i(poll_oe), .pp_d_i(poll_d),
        .bus_ev_o(bus_ev));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk_sys_i);
        req_q <= '{ad, v, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        req_q <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, output logic [7:0] v);
        @(posedge clk_sys_i);
        req_q <= '{ad, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        req_q <= '0;
        #1;
        v = rdata;
    endtask : rd
    task automatic pulse(input int b);
        @(posedge clk_sys_i);
        cmd_q <= isr_pkg::isr_bus_ev_type'(9'h001 << b);
        @(posedge clk_sys_i);
        cmd_q <= '0;
        #1;
    endtask : pulse
    task automatic hit(input int b);
        @(posedge clk_sys_i);
        misc_q <= 4'h1 << b;
        @(posedge clk_sys_i);
        misc_q <= '0;
        #1;
    endtask : hit
    function automatic logic [7:0] pp_exp(input logic [4:0] ad);
        return (ad <= isr_pkg::PPOLL_ADDR_MAX) ? 8'h01 << ad : 8'h00;
    endfunction : pp_exp
    function automatic logic [7:0] sp_exp(input logic [3:0] f);
        return {4'h4, f};
    endfunction : sp_exp
    initial begin
        void'($urandom(32'h6e9c06e9));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(isr_pkg::REG_ADDR, d);
        chk(d, {3'h0, isr_pkg::ADDR_RESET});
        wr(isr_pkg::REG_IRQ_MASK, 8'h00);
        hit(0);
        chk({6'h0, srq, srq_ind}, 8'h03);
        rd(isr_pkg::REG_STATUS, d);
        chk(d & 8'h60, 8'h60);
        x = irq;
        wr(isr_pkg::REG_IRQ_MASK, 8'h0F);
        tick(2);
        chk({7'h0, x ^ irq}, 8'h01);
        rd(isr_pkg::REG_IRQ_STAT, d);
        chk(d & 8'h01, 8'h01);
        tick(2);
        chk({7'h0, irq}, 8'h00);
        pulse(8);
        chk({7'h0, srq}, 8'h00);
        @(posedge clk_sys_i);
        fault_q <= 4'h1 << $urandom_range(3);
        tick(2);
        chk({7'h0, srq}, 8'h01);
        pulse(8);
        chk(poll_d & 8'h4F, sp_exp(fault_q));
        chk(poll_oe, 8'hFF);
        chk({6'h0, srq, srq_ind}, 8'h00);
        @(posedge clk_sys_i);
        fault_q <= '0;
        hit(0);
        pulse(6);
        chk({7'h0, srq}, 8'h00);
        wr(isr_pkg::REG_CTRL, 8'h00);
        hit(1);
        chk({7'h0, srq}, 8'h00);
        wr(isr_pkg::REG_CTRL, 8'h01);
        hit(1);
        chk({7'h0, srq}, 8'h01);
        pulse(8);
        wr(isr_pkg::REG_ADDR, 8'h1F);
        tick(2);
        chk({7'h0, a_err}, 8'h01);
        rd(isr_pkg::REG_ADDR, d);
        chk(d & 8'h1F, {3'h0, isr_pkg::ADDR_RESET});
        wr(isr_pkg::REG_ADDR, 8'h1E);
        rd(isr_pkg::REG_ADDR, d);
        chk(d & 8'h1F, 8'h1E);
        for (int i = 0; i < 4; i++) begin
            a = (i < 2) ? 5'($urandom_range(7)) : 5'($urandom_range(30, 8));
            wr(isr_pkg::REG_ADDR, {3'h0, a});
            hit(0);
            pulse(7);
            chk(poll_oe, pp_exp(a));
            chk(poll_d & poll_oe, pp_exp(a));
            chk({7'h0, srq}, 8'h01);
            tick(1);
            chk({7'h0, srq}, {7'h0, a > 5'd7});
            pulse(6);
        end
        // Configured answer: enable plus sense 1 on a random line
        ln = 3'($urandom_range(7));
        wr(isr_pkg::REG_PPOLL_CFG, 8'h18 | {5'h00, ln});
        pulse(7);
        chk(poll_oe, 8'h01 << ln);
        chk(poll_d, 8'h00);
        hit(0);
        pulse(7);
        chk(poll_d & poll_oe, 8'h01 << ln);
        chk({7'h0, srq}, 8'h01);
        tick(1);
        chk({7'h0, srq}, 8'h00);
        wr(isr_pkg::REG_PPOLL_CFG, 8'h00);
        pulse(5);
        tick(1);
        chk({7'h0, remote}, 8'h01);
        hit(3);
        chk({7'h0, pw_en}, 8'h00);
        @(posedge clk_sys_i);
        busy_q <= 1'b1;
        hit(2);
        tick(1);
        chk({7'h0, remote}, 8'h01);
        @(posedge clk_sys_i);
        busy_q <= 1'b0;
        hit(2);
        tick(1);
        chk({7'h0, remote}, 8'h00);
        hit(3);
        chk({7'h0, pw_en}, 8'h01);
        pulse(5);
        pulse(3);
        hit(2);
        tick(1);
        chk({7'h0, remote}, 8'h01);
        hit(3);
        chk({7'h0, pw_en}, 8'h00);
        pulse(2);
        pulse(4);
        tick(1);
        chk({7'h0, remote}, 8'h00);
        rd(isr_pkg::REG_ADDR, d);
        chk(d & 8'h1F, {3'h0, a});
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_i);
            cmd_q <= isr_pkg::isr_bus_ev_type'(9'h001 << i);
            tick(3);
            chk({7'h0, a_ind}, 8'h01);
            @(posedge clk_sys_i);
            cmd_q <= '0;
            tick(3);
            chk({7'h0, a_ind}, 8'h00);
        end
        final_report();
    end
    initial begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule : ieee488_service_request_remote_tb_top
